// ===== logic/rx_cfg.svh
// Function
// - Clock recovery drives recovered clock on output
// - Data leaves on rising or falling edge
// - Data recovery clock is XOR of rails
// - Powered-down receiver floats its clock output
// - Reference held high selects raw slicing
// - Reference held low floats all receive outputs
// - Transmit mode from reference and transmit clock
// - No wait states without reference clock
// - Loss flag sets on no transitions
// - Loss flag clears itself on enough ones
// - Top pin selects hardware, serial, parallel
// - Two lower pins select parallel bus variant
// - Middle pin selects multiplexed address/data
// - Serial mode uses only five serial pins
// - Low pin selects Motorola or Intel style
`ifndef RX_CFG_SVH
`define RX_CFG_SVH

// ********************************************************
// Timing
// ********************************************************
`define CORE_PERIOD_NS 10
`define MCLK_IDLE_NS 1300
`define MCLK_IDLE_CYC \
  ((`MCLK_IDLE_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`define MCLK_T1_KHZ 1544
`define TCLK_IDLE_MCLK 64
`define TCLK_IDLE_CYC \
  ((`TCLK_IDLE_MCLK * 1000000 + `MCLK_T1_KHZ * `CORE_PERIOD_NS - 1) \
   / (`MCLK_T1_KHZ * `CORE_PERIOD_NS))
`define BIT_CYCLES 6
`define LOS_ZERO_RUN 32
`define LOS_WINDOW 32
`define LOS_ONES_MIN 4
`define LOS_TIMEOUT_NS 2000
`define LOS_TIMEOUT_CYC \
  ((`LOS_TIMEOUT_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`define FIFO_DEPTH 4

// ********************************************************
// Strap fields and level codes
// ********************************************************
`define CFG_TOP_LSB 0
`define CFG_MID_BIT 2
`define CFG_LOW_BIT 3
`define CFG_EDGE_BIT 4
`define LVL_LOW 2'b00
`define LVL_MID 2'b01
`define LVL_HIGH 2'b11

`endif

// ===== logic/rx_pkg.sv
package rx_pkg;
  typedef enum logic [2:0] {
    ctrl_hw = 3'b001,
    ctrl_serial = 3'b010,
    ctrl_parallel = 3'b100
  } ctrl_mode_type;

  typedef enum logic [3:0] {
    bus_none = 4'b0000,
    bus_moto_sep = 4'b0001,
    bus_intel_sep = 4'b0010,
    bus_moto_mux = 4'b0100,
    bus_intel_mux = 4'b1000
  } bus_variant_type;

  typedef enum logic [2:0] {
    rx_off = 3'b001,
    rx_data = 3'b010,
    rx_clock = 3'b100
  } rx_mode_type;

  typedef enum logic [4:0] {
    tx_clocked = 5'b00001,
    tx_idle_low = 5'b00010,
    tx_idle_high = 5'b00100,
    tx_tclk_ref = 5'b01000,
    tx_off = 5'b10000
  } tx_mode_type;
endpackage

// ===== logic/stream_if.sv
`timescale 1ns/10ps
interface stream_if #(
  parameter int WIDTH = 8
) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== logic/sample_fifo.sv
`timescale 1ns/10ps
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  stream_if.snk in_s,
  stream_if.src out_s
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] count;
  } fifo_state_type;

  fifo_state_type q, d;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    next_ptr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // Honest flags straight from the occupancy count
  assign in_s.ready = q.count != CW'(DEPTH);
  assign out_s.valid = q.count != '0;
  assign out_s.data = q.mem[q.rd];
  assign push = ce && in_s.valid && in_s.ready;
  assign pop = ce && out_s.valid && out_s.ready;

  // Pointer and count update
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = in_s.data;
      d.wr = next_ptr(q.wr);
    end
    if (pop) begin
      d.rd = next_ptr(q.rd);
    end
    if (push && !pop) begin
      d.count = q.count + CW'(1);
    end else if (pop && !push) begin
      d.count = q.count - CW'(1);
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // sample_fifo

// ===== logic/los_monitor.sv
`timescale 1ns/10ps
`include "rx_cfg.svh"
module los_monitor #(
  parameter int ZERO_RUN = `LOS_ZERO_RUN,
  parameter int WINDOW = `LOS_WINDOW,
  parameter int ONES_MIN = `LOS_ONES_MIN,
  parameter int TIMEOUT = `LOS_TIMEOUT_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic bit_strobe,
  input wire logic bit_mark,
  output logic loss_flag
);
  typedef struct packed {
    logic [15:0] zero_run;
    logic [15:0] win;
    logic [15:0] ones;
    logic [15:0] idle;
    logic flag;
  } los_state_type;

  los_state_type q, d;

  // Zero run, density window and idle timeout
  always_comb begin
    d = q;
    if (ce) begin
      if (q.idle != 16'(TIMEOUT)) begin
        d.idle = q.idle + 16'h0001;
      end
      if (bit_strobe) begin
        if (bit_mark) begin
          d.zero_run = 16'h0000;
          d.idle = 16'h0000;
          d.ones = q.ones + 16'h0001;
        end else if (q.zero_run != 16'(ZERO_RUN)) begin
          d.zero_run = q.zero_run + 16'h0001;
        end
        d.win = q.win + 16'h0001;
        // Window end decides density; clears need a full good window
        if (q.win == 16'(WINDOW - 1)) begin
          if (d.ones < 16'(ONES_MIN)) begin
            d.flag = 1'b1;
          end else if (d.zero_run != 16'(ZERO_RUN)) begin
            d.flag = 1'b0;
          end
          d.win = 16'h0000;
          d.ones = 16'h0000;
        end
      end
      // A dead line or a long zero run sets at once
      if (d.zero_run == 16'(ZERO_RUN) || d.idle == 16'(TIMEOUT)) begin
        d.flag = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign loss_flag = q.flag;
endmodule // los_monitor

// ===== logic/rx_line_front.sv
`timescale 1ns/10ps
`include "rx_cfg.svh"
module rx_line_front #(
  parameter int NCH = 4,
  parameter int BIT_CYCLES = `BIT_CYCLES,
  parameter int MCLK_IDLE = `MCLK_IDLE_CYC,
  parameter int TCLK_IDLE = `TCLK_IDLE_CYC,
  parameter int LOS_TIMEOUT = `LOS_TIMEOUT_CYC,
  parameter int LOS_ZERO_RUN = `LOS_ZERO_RUN,
  parameter int LOS_WINDOW = `LOS_WINDOW,
  parameter int LOS_ONES_MIN = `LOS_ONES_MIN,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic line_clk,
  input wire logic [NCH-1:0] line_receive_pair_pos,
  input wire logic [NCH-1:0] line_receive_pair_neg,
  input wire logic master_clock_in,
  input wire logic [NCH-1:0] transmit_clock_in,
  input wire logic [NCH-1:0] rx_power_down,
  input wire logic clock_edge_select,
  input wire logic [1:0] control_select_top_lvl,
  input wire logic control_select_middle,
  input wire logic control_select_low,
  output logic [NCH-1:0] recv_clock_out,
  output logic [NCH-1:0] recv_clock_oe,
  output logic [NCH-1:0] rx_positive_data,
  output logic [NCH-1:0] rx_negative_data,
  output logic [NCH-1:0] rx_data_oe,
  output logic [NCH-1:0] signal_loss_flag,
  output logic [NCH-1:0][4:0] tx_mode,
  output logic [2:0] ctrl_mode,
  output logic [3:0] bus_variant,
  output logic bus_multiplexed,
  output logic bus_intel_style,
  output logic serial_port_enable,
  output logic parallel_port_enable,
  output logic wait_state_enable,
  output logic mode_strap_fault
);
  localparam int WW = 2 * NCH;
  localparam int HALF = BIT_CYCLES / 2;

  // ********************************************************
  // State types
  // ********************************************************
  typedef struct packed {
    logic ce_meta;
    logic ce_sync;
    logic ack_meta;
    logic ack_sync;
    logic req;
    logic [WW-1:0] word;
  } link_state_type;

  typedef struct packed {
    logic mclk_meta;
    logic mclk_sync;
    logic mclk_prev;
    logic [NCH-1:0] tclk_meta;
    logic [NCH-1:0] tclk_sync;
    logic [NCH-1:0] tclk_prev;
    logic [WW-1:0] pair_meta;
    logic [WW-1:0] pair_sync;
    logic [NCH-1:0] mark_prev;
    logic [4:0] cfg_meta;
    logic [4:0] cfg_sync;
    logic req_meta;
    logic req_sync;
    logic ack;
    logic [15:0] mclk_idle;
    logic [NCH-1:0][15:0] tclk_idle;
    logic [15:0] phase;
    logic [WW-1:0] bit_word;
    logic [NCH-1:0] rclk;
    logic [NCH-1:0] pos;
    logic [NCH-1:0] neg;
    logic [NCH-1:0] clk_oe;
    logic [NCH-1:0] data_oe;
    rx_pkg::tx_mode_type [NCH-1:0] tx;
    rx_pkg::ctrl_mode_type ctrl;
    rx_pkg::bus_variant_type variant;
    logic muxed;
    logic intel;
    logic strap_fault;
    logic wait_en;
  } core_state_type;

  link_state_type lq, ld;
  core_state_type cq, cd;
  rx_pkg::rx_mode_type [NCH-1:0] rxm;
  logic [NCH-1:0] strobe;
  logic [NCH-1:0] mark;
  logic mclk_active;
  logic tclk_edge;
  logic at_end;
  logic near_fall;
  logic pop;
  logic edge_sel;
  logic [1:0] top_lvl;

  stream_if #(.WIDTH(WW)) fifo_in ();
  stream_if #(.WIDTH(WW)) fifo_out ();

  // Saturating step shared by all idle counters
  function automatic logic [15:0] step16(input logic [15:0] v,
                                         input logic [15:0] lim);
    step16 = (v == lim) ? v : v + 16'h0001;
  endfunction

  // ********************************************************
  // Link domain: line sampling and toggle request
  // ********************************************************
  // Only one word is in flight; samples taken while the core
  // has not yet acknowledged are dropped, which trades bit
  // density for a simple and safe word crossing.
  always_comb begin
    ld = lq;
    ld.ce_meta = ce;
    ld.ce_sync = lq.ce_meta;
    ld.ack_meta = cq.ack;
    ld.ack_sync = lq.ack_meta;
    if (lq.ce_sync && (lq.req == lq.ack_sync)) begin
      ld.word = {line_receive_pair_neg, line_receive_pair_pos};
      ld.req = ~lq.req;
    end
  end

  // Link register, clocked by the line's own clock
  always_ff @(posedge line_clk or posedge rst) begin
    if (rst) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  // ********************************************************
  // Crossing into the core and the sample buffer
  // ********************************************************
  // The word is stable while a request is pending
  assign fifo_in.valid = cq.req_sync != cq.ack;
  assign fifo_in.data = lq.word;
  assign fifo_out.ready = pop;

  sample_fifo #(
    .WIDTH(WW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .in_s(fifo_in),
    .out_s(fifo_out)
  );

  // ********************************************************
  // Core domain
  // ********************************************************
  // Decoded views of the current state
  always_comb begin
    mclk_active = cq.mclk_idle != 16'(MCLK_IDLE);
    at_end = cq.phase == 16'(BIT_CYCLES - 1);
    near_fall = cq.phase == 16'(HALF - 1);
    edge_sel = cq.cfg_sync[`CFG_EDGE_BIT];
    top_lvl = cq.cfg_sync[`CFG_TOP_LSB +: 2];
    pop = ce && at_end;
    for (int ch = 0; ch < NCH; ch++) begin
      if (rx_power_down[ch]) begin
        rxm[ch] = rx_pkg::rx_off;
      end else if (!mclk_active && !cq.mclk_sync) begin
        rxm[ch] = rx_pkg::rx_off;
      end else if (mclk_active) begin
        rxm[ch] = rx_pkg::rx_clock;
      end else begin
        rxm[ch] = rx_pkg::rx_data;
      end
    end
  end

  // Next state of the core
  always_comb begin
    cd = cq;
    strobe = '0;
    mark = '0;
    tclk_edge = 1'b0;
    if (ce) begin
      // Pin synchronisers, two stages each
      cd.mclk_meta = master_clock_in;
      cd.mclk_sync = cq.mclk_meta;
      cd.mclk_prev = cq.mclk_sync;
      cd.tclk_meta = transmit_clock_in;
      cd.tclk_sync = cq.tclk_meta;
      cd.tclk_prev = cq.tclk_sync;
      cd.pair_meta = {line_receive_pair_neg, line_receive_pair_pos};
      cd.pair_sync = cq.pair_meta;
      cd.cfg_meta = {clock_edge_select, control_select_low,
                     control_select_middle, control_select_top_lvl};
      cd.cfg_sync = cq.cfg_meta;
      cd.req_meta = lq.req;
      cd.req_sync = cq.req_meta;

      // Reference activity; a stuck level saturates the counter
      if (cq.mclk_sync != cq.mclk_prev) begin
        cd.mclk_idle = 16'h0000;
      end else begin
        cd.mclk_idle = step16(cq.mclk_idle, 16'(MCLK_IDLE));
      end

      // Accept the crossed word when the buffer has room
      if (fifo_in.valid && fifo_in.ready) begin
        cd.ack = ~cq.ack;
      end

      // Bit timer and word pop at the end of each bit
      cd.phase = at_end ? 16'h0000 : cq.phase + 16'h0001;
      if (at_end) begin
        cd.bit_word = fifo_out.valid ? fifo_out.data : '0;
      end

      // Per-channel receive outputs and loss inputs
      for (int ch = 0; ch < NCH; ch++) begin
        cd.mark_prev[ch] = cq.pair_sync[ch] | cq.pair_sync[NCH + ch];
        case (rxm[ch])
          rx_pkg::rx_clock: begin
            cd.rclk[ch] = cd.phase < 16'(HALF);
            if ((at_end && edge_sel) || (near_fall && !edge_sel)) begin
              cd.pos[ch] = cd.bit_word[ch];
              cd.neg[ch] = cd.bit_word[NCH + ch];
            end
            cd.clk_oe[ch] = 1'b1;
            cd.data_oe[ch] = 1'b1;
            strobe[ch] = at_end;
            mark[ch] = at_end && fifo_out.valid &&
                       (fifo_out.data[ch] | fifo_out.data[NCH + ch]);
          end
          rx_pkg::rx_data: begin
            // Raw slices; polarity follows the edge select strap
            cd.pos[ch] = edge_sel ? cq.pair_sync[ch] :
                         ~cq.pair_sync[ch];
            cd.neg[ch] = edge_sel ? cq.pair_sync[NCH + ch] :
                         ~cq.pair_sync[NCH + ch];
            cd.rclk[ch] = cd.pos[ch] ^ cd.neg[ch];
            cd.clk_oe[ch] = 1'b1;
            cd.data_oe[ch] = 1'b1;
            strobe[ch] = cd.mark_prev[ch] && !cq.mark_prev[ch];
            mark[ch] = strobe[ch];
          end
          default: begin
            cd.rclk[ch] = 1'b0;
            cd.pos[ch] = 1'b0;
            cd.neg[ch] = 1'b0;
            cd.clk_oe[ch] = 1'b0;
            cd.data_oe[ch] = 1'b0;
          end
        endcase

        // Transmit clock activity over the idle limit
        tclk_edge = cq.tclk_sync[ch] != cq.tclk_prev[ch];
        if (tclk_edge) begin
          cd.tclk_idle[ch] = 16'h0000;
        end else begin
          cd.tclk_idle[ch] = step16(cq.tclk_idle[ch], 16'(TCLK_IDLE));
        end
        if (mclk_active) begin
          if (cq.tclk_idle[ch] != 16'(TCLK_IDLE)) begin
            cd.tx[ch] = rx_pkg::tx_clocked;
          end else if (cq.tclk_sync[ch]) begin
            cd.tx[ch] = rx_pkg::tx_idle_high;
          end else begin
            cd.tx[ch] = rx_pkg::tx_idle_low;
          end
        end else if (cq.tclk_idle[ch] != 16'(TCLK_IDLE)) begin
          cd.tx[ch] = rx_pkg::tx_tclk_ref;
        end else begin
          cd.tx[ch] = rx_pkg::tx_off;
        end
      end

      // Three-level top pin; the unused code reads as mid
      if (top_lvl == `LVL_LOW) begin
        cd.ctrl = rx_pkg::ctrl_hw;
      end else if (top_lvl == `LVL_HIGH) begin
        cd.ctrl = rx_pkg::ctrl_parallel;
      end else begin
        cd.ctrl = rx_pkg::ctrl_serial;
      end

      // Parallel bus variant from the two lower pins
      if (cd.ctrl == rx_pkg::ctrl_parallel) begin
        cd.muxed = cq.cfg_sync[`CFG_MID_BIT];
        cd.intel = cq.cfg_sync[`CFG_LOW_BIT];
        case ({cd.muxed, cd.intel})
          2'b00: cd.variant = rx_pkg::bus_moto_sep;
          2'b01: cd.variant = rx_pkg::bus_intel_sep;
          2'b10: cd.variant = rx_pkg::bus_moto_mux;
          default: cd.variant = rx_pkg::bus_intel_mux;
        endcase
        cd.strap_fault = 1'b0;
      end else begin
        cd.muxed = 1'b0;
        cd.intel = 1'b0;
        cd.variant = rx_pkg::bus_none;
        // Middle pin should be grounded here
        cd.strap_fault = cq.cfg_sync[`CFG_MID_BIT];
      end

      // Wait states need a running reference
      cd.wait_en = (cd.ctrl == rx_pkg::ctrl_parallel) &&
                   mclk_active;
    end
  end

  // Core register; reset leaves outputs floated, control mode at hardware and transmit modes off
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cq <= '{tx: '{default: rx_pkg::tx_off}, ctrl: rx_pkg::ctrl_hw,
              variant: rx_pkg::bus_none, default: '0};
    end else begin
      cq <= cd;
    end
  end

  // ********************************************************
  // Loss monitors
  // ********************************************************
  for (genvar ch = 0; ch < NCH; ch++) begin : g_los
    los_monitor #(
      .ZERO_RUN(LOS_ZERO_RUN),
      .WINDOW(LOS_WINDOW),
      .ONES_MIN(LOS_ONES_MIN),
      .TIMEOUT(LOS_TIMEOUT)
    ) u_los (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .bit_strobe(strobe[ch]),
      .bit_mark(mark[ch]),
      .loss_flag(signal_loss_flag[ch])
    );
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  // All from the core register
  assign recv_clock_out = cq.rclk;
  assign recv_clock_oe = cq.clk_oe;
  assign rx_positive_data = cq.pos;
  assign rx_negative_data = cq.neg;
  assign rx_data_oe = cq.data_oe;
  assign tx_mode = cq.tx;
  assign ctrl_mode = cq.ctrl;
  assign bus_variant = cq.variant;
  assign bus_multiplexed = cq.muxed;
  assign bus_intel_style = cq.intel;
  // Serial mode exposes only the serial port pins
  assign serial_port_enable = cq.ctrl == rx_pkg::ctrl_serial;
  assign parallel_port_enable = cq.ctrl == rx_pkg::ctrl_parallel;
  assign wait_state_enable = cq.wait_en;
  assign mode_strap_fault = cq.strap_fault;
endmodule // rx_line_front

// ===== tb/rx_line_front_asserts.sv
`timescale 1ns/10ps
module rx_line_front_asserts #(
  parameter int MCLK_IDLE = 130,
  parameter int LOS_TIMEOUT = 200
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] line_receive_pair_pos,
  input wire logic [3:0] line_receive_pair_neg,
  input wire logic master_clock_in,
  input wire logic [3:0] rx_power_down,
  input wire logic [1:0] control_select_top_lvl,
  input wire logic control_select_middle,
  input wire logic [3:0] recv_clock_out,
  input wire logic [3:0] recv_clock_oe,
  input wire logic [3:0] rx_positive_data,
  input wire logic [3:0] rx_negative_data,
  input wire logic [3:0] rx_data_oe,
  input wire logic [3:0] signal_loss_flag,
  input wire logic [2:0] ctrl_mode,
  input wire logic [3:0] bus_variant,
  input wire logic bus_multiplexed,
  input wire logic bus_intel_style,
  input wire logic serial_port_enable,
  input wire logic parallel_port_enable,
  input wire logic wait_state_enable,
  input wire logic mode_strap_fault
);
  localparam int STUCK = MCLK_IDLE + 10;
  localparam int QUIET = LOS_TIMEOUT + 10;
  logic [15:0] hi_q, lo_q, quiet_q;
  // ************************************
  // Reference level and line quiet counters
  // ************************************
  // Saturating, so a long stuck level never wraps back into range
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hi_q <= 16'h0000;
      lo_q <= 16'h0000;
      quiet_q <= 16'h0000;
    end else begin
      hi_q <= (ce && master_clock_in) ? hi_q + 16'(~&hi_q) : 16'h0000;
      lo_q <= (ce && !master_clock_in) ? lo_q + 16'(~&lo_q) : 16'h0000;
      if (!ce || !recv_clock_oe[0] || line_receive_pair_pos[0]
          || line_receive_pair_neg[0])
        quiet_q <= 16'h0000;
      else
        quiet_q <= quiet_q + 16'(quiet_q != 16'hffff);
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Steady-pin windows; decode lags the pins by three edges
  sequence pins_steady;
    ($stable(control_select_top_lvl) && ce)[*5];
  endsequence
  sequence middle_misstrapped;
    (control_select_middle && control_select_top_lvl != 2'b11 && ce)[*5];
  endsequence
  AST_MODE_DECODE: assert property (pins_steady |-> ctrl_mode ==
    (control_select_top_lvl == 2'b00 ? 3'b001 :
     control_select_top_lvl == 2'b11 ? 3'b100 : 3'b010))
    else $error("mode bad");
  AST_BUS_VARIANT: assert property (bus_variant == (
    parallel_port_enable ? {bus_multiplexed & bus_intel_style,
    bus_multiplexed & !bus_intel_style, !bus_multiplexed & bus_intel_style,
    !bus_multiplexed & !bus_intel_style} : 4'h0)) else $error("bus variant bad");
  AST_SERIAL_ONLY: assert property (serial_port_enable |->
    ctrl_mode == 3'b010 && !parallel_port_enable) else $error("port enables");
  AST_STRAP_FAULT: assert property (middle_misstrapped |->
    mode_strap_fault) else $error("strap fault missing");
  AST_POWER_DOWN_FLOAT: assert property ((rx_power_down &
    $past(rx_power_down) & $past(rx_power_down, 2) & recv_clock_oe) == 4'h0)
    else $error("powered-down clock driven");
  AST_STUCK_LOW_FLOAT: assert property (lo_q >= 16'(STUCK) |->
    (rx_data_oe | recv_clock_oe) == 4'h0) else $error("outputs not floated");
  AST_NO_WAIT_STATE: assert property ((lo_q >= 16'(STUCK) ||
    hi_q >= 16'(STUCK)) |-> !wait_state_enable) else $error("wait state on");
  AST_RAW_XOR: assert property (hi_q >= 16'(STUCK) |->
    ((recv_clock_out ^ rx_positive_data ^ rx_negative_data) & recv_clock_oe)
    == 4'h0) else $error("raw clock not xor");
  AST_LOSS_SET: assert property (quiet_q >= 16'(QUIET) |->
    signal_loss_flag[0]) else $error("loss flag missing");
endmodule // rx_line_front_asserts
bind rx_line_front rx_line_front_asserts #(.MCLK_IDLE(MCLK_IDLE),
  .LOS_TIMEOUT(LOS_TIMEOUT)) chk (.core_clk, .rst, .ce,
  .line_receive_pair_pos, .line_receive_pair_neg, .master_clock_in,
  .rx_power_down, .control_select_top_lvl, .control_select_middle,
  .recv_clock_out, .recv_clock_oe, .rx_positive_data, .rx_negative_data,
  .rx_data_oe, .signal_loss_flag, .ctrl_mode, .bus_variant, .bus_multiplexed,
  .bus_intel_style, .serial_port_enable, .parallel_port_enable,
  .wait_state_enable, .mode_strap_fault);

// ===== tb/line_source.sv
`timescale 1ns/10ps
module line_source (
  input wire logic line_clk,
  input wire logic [1:0] ref_mode,
  input wire logic marks_on,
  output logic master_clock_in,
  output logic [3:0] transmit_clock_in,
  output logic [3:0] line_receive_pair_pos,
  output logic [3:0] line_receive_pair_neg
);
  logic [1:0] phase_q;
  initial begin
    master_clock_in = 1'b0;
    phase_q = 2'b00;
    line_receive_pair_pos = 4'h0;
    line_receive_pair_neg = 4'h0;
  end
  // Reference at the T1 rate, or parked high or low
  always begin
    #324;
    case (ref_mode)
      2'd0: master_clock_in = ~master_clock_in;
      2'd1: master_clock_in = 1'b1;
      default: master_clock_in = 1'b0;
    endcase
  end
  assign transmit_clock_in = {4{master_clock_in}};
  // Alternating marks apart by a space, as bipolar ones arrive
  always @(negedge line_clk) begin
    phase_q <= phase_q + 2'b01;
    line_receive_pair_pos <= {4{marks_on && phase_q == 2'b00}};
    line_receive_pair_neg <= {4{marks_on && phase_q == 2'b10}};
  end
endmodule // line_source

// ===== tb/rx_line_front_bench.sv
`timescale 1ns/10ps
module rx_line_front_bench;
  logic core_clk = 1'b0, line_clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic master_clock_in, clock_edge_select = 1'b1, marks_on = 1'b1;
  logic control_select_middle = 1'b0, control_select_low = 1'b0;
  logic bus_multiplexed, bus_intel_style, serial_port_enable;
  logic parallel_port_enable, wait_state_enable, mode_strap_fault;
  logic [1:0] control_select_top_lvl = 2'b00, ref_mode = 2'd0;
  logic [2:0] ctrl_mode;
  logic [3:0] transmit_clock_in, line_receive_pair_pos, line_receive_pair_neg;
  logic [3:0] rx_power_down = 4'h0, recv_clock_out, recv_clock_oe;
  logic [3:0] rx_positive_data, rx_negative_data, rx_data_oe;
  logic [3:0] signal_loss_flag, bus_variant, seen_p, seen_c;
  logic [3:0][4:0] tx_mode;
  logic [3:0] tv [7] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'hd, 4'he, 4'hf};
  logic [2:0] ec [7] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h4, 3'h4};
  logic [3:0] eb [7] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
  int n_errors = 0, num_checks = 0, rises, bad;
  always #5 core_clk = ~core_clk;
  initial #7 forever #15 line_clk = ~line_clk;
  line_source far (.line_clk, .ref_mode, .marks_on, .master_clock_in,
    .transmit_clock_in, .line_receive_pair_pos, .line_receive_pair_neg);
  rx_line_front #(.MCLK_IDLE(60), .TCLK_IDLE(64)) uut (.core_clk, .rst, .ce,
    .line_clk, .line_receive_pair_pos, .line_receive_pair_neg,
    .master_clock_in, .transmit_clock_in, .rx_power_down, .clock_edge_select,
    .control_select_top_lvl, .control_select_middle, .control_select_low,
    .recv_clock_out, .recv_clock_oe, .rx_positive_data, .rx_negative_data,
    .rx_data_oe, .signal_loss_flag, .tx_mode, .ctrl_mode, .bus_variant,
    .bus_multiplexed, .bus_intel_style, .serial_port_enable,
    .parallel_port_enable, .wait_state_enable, .mode_strap_fault);
  // ************************************
  // Compare and report tasks
  // ************************************
  task automatic chk_flag(input string what, input logic [3:0] e,
                          input logic [3:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_code(input string what, input logic [4:0] e,
                          input logic [4:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Straps go through two flops and a decode, so allow six edges
  task automatic set_pins(input logic [3:0] v);
    control_select_top_lvl = v[3:2];
    control_select_middle = v[1];
    control_select_low = v[0];
    repeat (6) @(negedge core_clk);
  endtask
  task automatic wait_loss(input logic [3:0] e, input int bound);
    int n;
    n = 0;
    while (signal_loss_flag !== e && n < bound) begin
      @(negedge core_clk);
      n++;
    end
    chk_flag("loss_flag", e, signal_loss_flag);
    if (signal_loss_flag !== e) summarize();
  endtask
  // ************************************
  // Test sequence
  // ************************************
  initial begin
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      set_pins(tv[i]);
      chk_code("ctrl_mode", {2'b00, ec[i]}, {2'b00, ctrl_mode});
      chk_flag("bus_variant", eb[i], bus_variant);
      chk_flag("bus_style", {2'b00, tv[i][1], tv[i][0]},
               {2'b00, bus_multiplexed, bus_intel_style});
      chk_flag("port_en", {2'b00, ec[i][2], ec[i][1]},
               {2'b00, parallel_port_enable, serial_port_enable});
    end
    chk_flag("wait_en", 4'h1, {3'b000, wait_state_enable});
    set_pins(4'b0010);
    chk_flag("strap_fault", 4'h1, {3'b000, mode_strap_fault});
    set_pins(4'b0000);
    $display("test modes done");
    repeat (100) @(negedge core_clk);
    chk_code("tx_mode", 5'b00001, tx_mode[0]);
    chk_flag("rclk_oe", 4'hf, recv_clock_oe);
    // Falling-edge select first, so the raw test below sees it high
    for (int k = 0; k < 2; k++) begin
      clock_edge_select = k[0];
      repeat (4) @(negedge core_clk);
      {rises, bad} = 64'h0;
      for (int i = 0; i < 60; i++) begin
        {seen_c, seen_p} = {recv_clock_out, rx_positive_data};
        @(negedge core_clk);
        rises += int'(!seen_c[0] && recv_clock_out[0]);
        bad += int'(seen_p[0] != rx_positive_data[0] &&
          {seen_c[0], recv_clock_out[0]} != {~k[0], k[0]});
      end
      chk_flag("rclk_rises", 4'ha, 4'(rises));
      chk_flag("rail_edge", 4'h0, 4'(bad));
    end
    rx_power_down = 4'b0010;
    repeat (3) @(negedge core_clk);
    chk_flag("rclk_oe", 4'b1101, recv_clock_oe);
    rx_power_down = 4'h0;
    $display("test recovery done");
    set_pins(4'hf);
    ref_mode = 2'd2;
    repeat (150) @(negedge core_clk);
    chk_flag("data_oe", 4'h0, rx_data_oe | recv_clock_oe);
    chk_flag("wait_en", 4'h0, {3'b000, wait_state_enable});
    ref_mode = 2'd1;
    repeat (150) @(negedge core_clk);
    {seen_p, seen_c} = 8'h00;
    repeat (40) begin
      @(negedge core_clk);
      seen_p |= rx_positive_data;
      seen_c |= recv_clock_out;
    end
    chk_flag("raw_rails", 4'hf, seen_p);
    chk_flag("raw_clock", 4'hf, seen_c);
    $display("test reference levels done");
    ref_mode = 2'd0;
    marks_on = 1'b0;
    repeat (150) @(negedge core_clk);
    wait_loss(4'hf, 400);
    marks_on = 1'b1;
    wait_loss(4'h0, 900);
    $display("test loss done");
    summarize();
  end
endmodule // rx_line_front_bench
